/* File: lsc_defs.svh */
// Constants for the LAN link statistics counter block.
//
// Functional notes
// RULE_01 - Count frames deferred on first attempt by busy medium
// RULE_02 - Count collisions later than 512 bit times
// RULE_03 - Count internal transmit path failures
// RULE_04 - Count transmits with carrier lost or absent
// RULE_05 - Count frames abandoned after excessive collisions
// RULE_06 - Count received frames above maximum size
// RULE_07 - Count received frames below minimum size
// RULE_08 - Count internal receive path failures
// RULE_09 - Clear request zeroes all adapter error counters
// RULE_10 - Link address is station address plus access point
// RULE_11 - Count information units sent, retransmissions included
// RULE_12 - Overflow or link init resets link counters
// RULE_13 - Count valid information units received, even out-of-sequence
// RULE_14 - Count conditions needing an information retransmission
// RULE_15 - Count information frames in error, excluding checksum failures
// RULE_16 - Count reply timer expiries per link
// RULE_17 - Hold last received and sent command codes
// RULE_18 - Report frame format as 802.3 or legacy
// RULE_19 - Host identifier limited to groups one to three
// RULE_20 - One-hot primary state plus combinable secondary byte
// RULE_21 - Eight-digit decimal counters with wrap overflow flags
`ifndef LSC_DEFS_SVH
`define LSC_DEFS_SVH

// ********************************************************************
// Sizes
// ********************************************************************
`define LSC_NUM_LINKS      4
`define LSC_LINK_W         2
`define LSC_NUM_AD_CNT     8
`define LSC_NUM_LK_CNT     5
`define LSC_DIGITS         8
`define LSC_ADDR_W         12
`define LSC_BIT_CNT_W      10

// ********************************************************************
// Adapter counter slots
// ********************************************************************
`define LSC_AD_DEFER       0
`define LSC_AD_LATE        1
`define LSC_AD_TXMAC       2
`define LSC_AD_CARRIER     3
`define LSC_AD_EXCESS      4
`define LSC_AD_LONG        5
`define LSC_AD_SHORT       6
`define LSC_AD_RXMAC       7

// ********************************************************************
// Link counter slots
// ********************************************************************
`define LSC_LK_TXI         0
`define LSC_LK_RXI         1
`define LSC_LK_TXERR       2
`define LSC_LK_RXERR       3
`define LSC_LK_T1          4

// ********************************************************************
// Timing and values
// ********************************************************************
`define LSC_LATE_COLL_BITS 10'h200
`define LSC_BCD_NINE       4'h9
`define LSC_PRI_CLOSED     8'h80
`define LSC_SEC_RESET      8'h00
`define LSC_GRP_MIN        2'h1
`define LSC_GRP_MAX        2'h3
`define LSC_LETTER_RESET   3'h0
`define LSC_LAP_RESET      8'h04
`define LSC_FMT_8023       1'b0

// ********************************************************************
// Register map (byte addresses)
// ********************************************************************
`define LSC_REG_CTRL       12'h000
`define LSC_REG_STA_LO     12'h004
`define LSC_REG_STA_HI     12'h008
`define LSC_REG_AD_OVF     12'h00C
`define LSC_AD_PAGE        6'h01
`define LSC_LINK_PAGE      4'h1
`define LSC_LW_OVF         4'h5
`define LSC_LW_CODES       4'h6
`define LSC_LW_STATE       4'h7
`define LSC_LW_HOST        4'h8
`define LSC_LW_INIT        4'h9
`define LSC_CTRL_CLR_AD    0
`define LSC_CTRL_CLR_LK    1
`define LSC_FMT_BIT        16
`define LSC_GRP_LSB        12
`define LSC_LETTER_LSB     8

`endif

/* File: lsc_pkg.sv */
// Types shared by the LAN link statistics counter block.
`include "lsc_defs.svh"

package lsc_pkg;

    typedef logic [31:0] lsc_bcd_t;

    typedef struct packed {
        logic [`LSC_NUM_LK_CNT-1:0][31:0] cnt;
        logic [`LSC_NUM_LK_CNT-1:0]       ovf;
        logic [7:0]                       cmd_rx;
        logic [7:0]                       cmd_tx;
        logic                             fmt;
        logic [7:0]                       pri;
        logic [7:0]                       sec;
        logic [1:0]                       grp;
        logic [2:0]                       letter;
        logic [7:0]                       local_access_point;
    } lsc_link_s;

    typedef struct packed {
        logic [`LSC_NUM_AD_CNT-1:0][31:0]    ad_cnt;
        logic [`LSC_NUM_AD_CNT-1:0]          ad_ovf;
        logic [47:0]                         station;
        lsc_link_s [`LSC_NUM_LINKS-1:0]      links;
        logic [`LSC_BIT_CNT_W-1:0]           bit_cnt;
        logic                                tx_active;
        logic [31:0]                         rdata;
    } lsc_state_s;

endpackage

/* File: lsc_stats.sv */
// LAN adapter and per-link statistics counters with a register port.
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "lsc_defs.svh"

module lsc_stats (
    input  wire logic                   clock,
    input  wire logic                   nrst,
    // Register port.
    input  wire logic [`LSC_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [31:0]            reg_rdata,
    // Adapter MAC events, one-cycle pulses.
    input  wire logic                   tx_start,
    input  wire logic                   tx_end,
    input  wire logic                   bit_tick,
    input  wire logic                   collision,
    input  wire logic                   tx_deferred,
    input  wire logic                   tx_mac_error,
    input  wire logic                   tx_carrier_lost,
    input  wire logic                   tx_excess_coll,
    input  wire logic                   rx_too_long,
    input  wire logic                   rx_too_short,
    input  wire logic                   rx_mac_error,
    // Link events, qualified by link_sel.
    input  wire logic [`LSC_LINK_W-1:0] link_sel,
    input  wire logic                   lk_i_sent,
    input  wire logic                   lk_i_rcvd,
    input  wire logic                   lk_retx_needed,
    input  wire logic                   lk_i_rx_err,
    input  wire logic                   lk_fcs_bad,
    input  wire logic                   lk_reply_expired,
    input  wire logic                   lk_cmd_rx_stb,
    input  wire logic [7:0]             lk_cmd_rx_code,
    input  wire logic                   lk_cmd_tx_stb,
    input  wire logic [7:0]             lk_cmd_tx_code,
    input  wire logic                   lk_init
);

    // ****************************************************************
    // Decimal arithmetic
    // ****************************************************************

    // Bit 32 of the result is the wrap carry out of the top digit.
    function automatic logic [32:0] bcd_inc(input logic [31:0] v);
        logic [31:0] r;
        logic        c;
        integer      d;

        r = v;
        c = 1'b1;
        for (d = 0; d < `LSC_DIGITS; d = d + 1) begin
            if (c) begin
                if (r[d*4 +: 4] == `LSC_BCD_NINE) begin
                    r[d*4 +: 4] = 4'h0;
                end else begin
                    r[d*4 +: 4] = r[d*4 +: 4] + 4'h1;
                    c = 1'b0;
                end
            end
        end
        return {c, r};
    endfunction

    // Zero is not one-hot.
    function automatic logic is_one_hot(input logic [7:0] v);
        return (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00);
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************

    lsc_pkg::lsc_state_s st_r;
    lsc_pkg::lsc_state_s st_nxt;

    logic [`LSC_NUM_AD_CNT-1:0] ad_evt;
    logic [`LSC_NUM_LK_CNT-1:0] lk_evt;

    logic                       late_coll;
    logic                       wr_ctrl;
    logic                       clr_ad;
    logic                       clr_lk_all;

    logic                       ad_hit;
    logic                       lk_hit;
    logic [`LSC_LINK_W-1:0]     lk_idx;
    logic [3:0]                 lk_word;
    logic [2:0]                 ad_idx;

    assign reg_rdata = st_r.rdata;

    assign ad_hit  = (reg_addr[`LSC_ADDR_W-1:6] == `LSC_AD_PAGE) && (reg_addr[5] == 1'b0);
    assign ad_idx  = reg_addr[4:2];

    assign lk_hit  = (reg_addr[`LSC_ADDR_W-1:8] == `LSC_LINK_PAGE);
    assign lk_idx  = reg_addr[7:6];
    assign lk_word = reg_addr[5:2];

    assign wr_ctrl = reg_wr && (reg_addr == `LSC_REG_CTRL);

    assign clr_ad     = wr_ctrl && reg_wdata[`LSC_CTRL_CLR_AD];                // see RULE_09
    assign clr_lk_all = wr_ctrl && reg_wdata[`LSC_CTRL_CLR_LK];

    // Only collisions past the slot time count; the bit counter saturates
    // just above the threshold so it never wraps back into the early window.
    assign late_coll = collision && st_r.tx_active
                       && (st_r.bit_cnt > `LSC_LATE_COLL_BITS);                // see RULE_02

    always_comb begin
        ad_evt                  = '0;

        ad_evt[`LSC_AD_DEFER]   = tx_deferred;                                 // see RULE_01
        ad_evt[`LSC_AD_LATE]    = late_coll;                                   // see RULE_02
        ad_evt[`LSC_AD_TXMAC]   = tx_mac_error;                                // see RULE_03
        ad_evt[`LSC_AD_CARRIER] = tx_carrier_lost;                             // see RULE_04
        ad_evt[`LSC_AD_EXCESS]  = tx_excess_coll;                              // see RULE_05
        ad_evt[`LSC_AD_LONG]    = rx_too_long;                                 // see RULE_06
        ad_evt[`LSC_AD_SHORT]   = rx_too_short;                                // see RULE_07
        ad_evt[`LSC_AD_RXMAC]   = rx_mac_error;                                // see RULE_08
    end

    always_comb begin
        lk_evt                 = '0;

        lk_evt[`LSC_LK_TXI]    = lk_i_sent;                                    // see RULE_11
        lk_evt[`LSC_LK_RXI]    = lk_i_rcvd;                                    // see RULE_13
        lk_evt[`LSC_LK_TXERR]  = lk_retx_needed;                               // see RULE_14
        lk_evt[`LSC_LK_RXERR]  = lk_i_rx_err && !lk_fcs_bad;                   // see RULE_15
        lk_evt[`LSC_LK_T1]     = lk_reply_expired;                             // see RULE_16
    end

    // ****************************************************************
    // Next state
    // ****************************************************************

    always_comb begin
        logic [32:0] inc;
        logic        wrap_any;
        logic        clr_link;
        logic [`LSC_NUM_LK_CNT-1:0][31:0] base;
        logic [`LSC_NUM_LK_CNT-1:0] ovf_base;
        logic [`LSC_NUM_LK_CNT-1:0] wrap;

        inc      = '0;
        wrap_any = 1'b0;
        clr_link = 1'b0;
        base     = '0;
        ovf_base = '0;
        wrap     = '0;

        st_nxt   = st_r;

        // Transmit bit timer for the late collision window.
        if (tx_start) begin
            st_nxt.tx_active = 1'b1;
            st_nxt.bit_cnt   = '0;
        end else if (tx_end) begin
            st_nxt.tx_active = 1'b0;
        end else if (st_r.tx_active && bit_tick
                     && (st_r.bit_cnt <= `LSC_LATE_COLL_BITS)) begin
            st_nxt.bit_cnt = st_r.bit_cnt + `LSC_BIT_CNT_W'(1);
        end

        // Adapter counters: a clear in the same cycle as an event leaves a
        // count of one, so the event is not lost.
        for (int i = 0; i < `LSC_NUM_AD_CNT; i++) begin
            if (clr_ad) begin                                                  // see RULE_09
                st_nxt.ad_cnt[i] = '0;
                st_nxt.ad_ovf[i] = 1'b0;
            end

            if (ad_evt[i]) begin
                inc = bcd_inc(clr_ad ? 32'h0000_0000 : st_r.ad_cnt[i]);        // see RULE_21
                st_nxt.ad_cnt[i] = inc[31:0];
                if (inc[32]) begin
                    st_nxt.ad_ovf[i] = 1'b1;
                end
            end
        end

        // Per-link counters, codes and configuration.
        for (int l = 0; l < `LSC_NUM_LINKS; l++) begin
            clr_link = clr_lk_all || (lk_init && (link_sel == l[`LSC_LINK_W-1:0]))
                       || (reg_wr && lk_hit && (lk_idx == l[`LSC_LINK_W-1:0])
                           && (lk_word == `LSC_LW_INIT) && reg_wdata[0]);      // see RULE_12

            base     = clr_link ? '0 : st_r.links[l].cnt;
            ovf_base = clr_link ? '0 : st_r.links[l].ovf;
            wrap     = '0;
            wrap_any = 1'b0;

            st_nxt.links[l].cnt = base;

            if (link_sel == l[`LSC_LINK_W-1:0]) begin
                for (int c = 0; c < `LSC_NUM_LK_CNT; c++) begin
                    if (lk_evt[c]) begin
                        inc = bcd_inc(base[c]);                                // see RULE_21
                        st_nxt.links[l].cnt[c] = inc[31:0];
                        wrap[c] = inc[32];
                    end
                end
                wrap_any = |wrap;

                if (lk_cmd_rx_stb) begin
                    st_nxt.links[l].cmd_rx = lk_cmd_rx_code;                   // see RULE_17
                end

                if (lk_cmd_tx_stb) begin
                    st_nxt.links[l].cmd_tx = lk_cmd_tx_code;                   // see RULE_17
                end
            end

            // A wrap restarts the whole set; the flag records which one wrapped.
            if (wrap_any) begin
                st_nxt.links[l].cnt = '0;                                      // see RULE_12
            end
            st_nxt.links[l].ovf = ovf_base | wrap;                             // see RULE_21

            if (reg_wr && lk_hit && (lk_idx == l[`LSC_LINK_W-1:0])) begin
                unique case (lk_word)
                    `LSC_LW_CODES: begin
                        st_nxt.links[l].fmt = reg_wdata[`LSC_FMT_BIT];         // see RULE_18
                    end

                    `LSC_LW_STATE: begin
                        // A primary pattern with other than one bit set is refused; the secondary byte is still written.
                        if (is_one_hot(reg_wdata[7:0])) begin
                            st_nxt.links[l].pri = reg_wdata[7:0];              // see RULE_20
                        end
                        st_nxt.links[l].sec = reg_wdata[15:8];                 // see RULE_20
                    end

                    `LSC_LW_HOST: begin
                        st_nxt.links[l].local_access_point = reg_wdata[7:0];   // see RULE_10
                        if ((reg_wdata[`LSC_GRP_LSB +: 2] >= `LSC_GRP_MIN)
                            && (reg_wdata[`LSC_GRP_LSB +: 2] <= `LSC_GRP_MAX)) begin
                            st_nxt.links[l].grp    = reg_wdata[`LSC_GRP_LSB +: 2]; // see RULE_19
                            st_nxt.links[l].letter = reg_wdata[`LSC_LETTER_LSB +: 3];
                        end
                    end

                    default: begin
                    end
                endcase
            end
        end

        // Station address writes.
        if (reg_wr && (reg_addr == `LSC_REG_STA_LO)) begin
            st_nxt.station[31:0] = reg_wdata;                                  // see RULE_10
        end

        if (reg_wr && (reg_addr == `LSC_REG_STA_HI)) begin
            st_nxt.station[47:32] = reg_wdata[15:0];                           // see RULE_10
        end

        // Read data stands for exactly the cycle after the strobe.
        st_nxt.rdata = 32'h0000_0000;

        if (reg_rd) begin
            if (reg_addr == `LSC_REG_STA_LO) begin
                st_nxt.rdata = st_r.station[31:0];
            end else if (reg_addr == `LSC_REG_STA_HI) begin
                st_nxt.rdata = {16'h0000, st_r.station[47:32]};
            end else if (reg_addr == `LSC_REG_AD_OVF) begin
                st_nxt.rdata = {24'h00_0000, st_r.ad_ovf};
            end else if (ad_hit) begin
                st_nxt.rdata = st_r.ad_cnt[ad_idx];
            end else if (lk_hit) begin
                if (lk_word < 4'(`LSC_NUM_LK_CNT)) begin
                    st_nxt.rdata = st_r.links[lk_idx].cnt[lk_word[2:0]];
                end else begin
                    unique case (lk_word)
                        `LSC_LW_OVF: begin
                            st_nxt.rdata = {27'h000_0000, st_r.links[lk_idx].ovf};
                        end

                        `LSC_LW_CODES: begin
                            st_nxt.rdata = {15'h0000, st_r.links[lk_idx].fmt,
                                            st_r.links[lk_idx].cmd_tx,
                                            st_r.links[lk_idx].cmd_rx};        // see RULE_17
                        end

                        `LSC_LW_STATE: begin
                            st_nxt.rdata = {16'h0000, st_r.links[lk_idx].sec,
                                            st_r.links[lk_idx].pri};           // see RULE_20
                        end

                        `LSC_LW_HOST: begin
                            st_nxt.rdata = {18'h0_0000, st_r.links[lk_idx].grp, 1'b0,
                                            st_r.links[lk_idx].letter,
                                            st_r.links[lk_idx].local_access_point};
                        end

                        default: begin
                            st_nxt.rdata = 32'h0000_0000;
                        end
                    endcase
                end
            end
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************

    // Link state resets to closed, not zero.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_r.ad_cnt    <= '0;
            st_r.ad_ovf    <= '0;
            st_r.station   <= '0;
            st_r.bit_cnt   <= '0;
            st_r.tx_active <= 1'b0;
            st_r.rdata     <= '0;

            for (int l = 0; l < `LSC_NUM_LINKS; l++) begin
                st_r.links[l].cnt    <= '0;
                st_r.links[l].ovf    <= '0;

                st_r.links[l].cmd_rx <= 8'h00;
                st_r.links[l].cmd_tx <= 8'h00;

                st_r.links[l].fmt    <= `LSC_FMT_8023;
                st_r.links[l].pri    <= `LSC_PRI_CLOSED;
                st_r.links[l].sec    <= `LSC_SEC_RESET;

                st_r.links[l].grp    <= `LSC_GRP_MIN;
                st_r.links[l].letter <= `LSC_LETTER_RESET;
                st_r.links[l].local_access_point <= `LSC_LAP_RESET;
            end
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule // lsc_stats

`default_nettype wire

/* File: lsc_medium.sv */
// Behavioural model of the LAN medium as seen by the transmit timing inputs.
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Medium model
// ****************************************
module lsc_medium (
    input  wire logic       clock,
    input  wire logic       go,
    input  wire logic [9:0] ticks,
    output var logic        tx_start,
    output var logic        bit_tick,
    output var logic        collision,
    output var logic        tx_end,
    output var logic        done
);
    initial begin
        {tx_start, bit_tick, collision, tx_end, done} = 5'h1F & 5'h01;
    end
    // One packet: start, a chosen number of bit times, a collision, then the end.
    always begin
        @(posedge clock);
        if (go) begin
            done <= 1'b0;
            tx_start <= 1'b1;
            @(posedge clock);
            tx_start <= 1'b0;
            for (int i = 0; i < ticks; i++) begin
                bit_tick <= 1'b1;
                @(posedge clock);
            end
            bit_tick <= 1'b0;
            collision <= 1'b1;
            @(posedge clock);
            collision <= 1'b0;
            tx_end <= 1'b1;
            @(posedge clock);
            tx_end <= 1'b0;
            done <= 1'b1;
        end
    end
endmodule // lsc_medium
`default_nettype wire

/* File: lsc_stats_monitor.sv */
// Checker for the LAN link statistics counter block.
`timescale 1ns/1ps
`default_nettype none
`include "lsc_defs.svh"
module lsc_stats_monitor (
    input wire logic                   clock,
    input wire logic                   nrst,
    input wire logic [`LSC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0]            reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [31:0]            reg_rdata,
    input wire logic                   tx_deferred,
    input wire logic [`LSC_LINK_W-1:0] link_sel,
    input wire logic                   lk_i_sent,
    input wire logic                   lk_init,
    input wire logic                   lk_cmd_rx_stb,
    input wire logic [7:0]             lk_cmd_rx_code
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    function automatic logic is_bcd(input logic [31:0] v);
        is_bcd = 1'b1;
        for (int i = 0; i < 8; i++) if (v[4*i+:4] > 4'h9) is_bcd = 1'b0;
    endfunction
    chk_clear_zeroes: assert property (
        reg_wr && reg_addr == 12'h000 && reg_wdata[0] && !tx_deferred ##1
        reg_rd && reg_addr == 12'h040 |=> reg_rdata == 32'h0) else $error("clear missed");
    chk_defer_counts: assert property (
        reg_wr && reg_addr == 12'h000 && reg_wdata[0] && !tx_deferred ##1 tx_deferred ##1
        reg_rd && reg_addr == 12'h040 |=> reg_rdata == 32'h1) else $error("defer miscount");
    chk_init_clears: assert property (
        lk_init && link_sel == 2'h0 && !lk_i_sent ##1 reg_rd && reg_addr == 12'h100
        |=> reg_rdata == 32'h0) else $error("link init missed");
    chk_code_latched: assert property (
        lk_cmd_rx_stb && link_sel == 2'h1 ##1 reg_rd && reg_addr == 12'h158
        |=> reg_rdata[7:0] == $past(lk_cmd_rx_code, 2)) else $error("code not held");
    chk_format_kept: assert property (
        reg_wr && reg_addr == 12'h158 ##1 reg_rd && reg_addr == 12'h158
        |=> reg_rdata[16] == $past(reg_wdata[16], 2)) else $error("format lost");
    chk_primary_onehot: assert property (
        reg_rd && reg_addr[11:8] == 4'h1 && reg_addr[5:0] == 6'h1C
        |=> $onehot(reg_rdata[7:0])) else $error("primary state not one-hot");
    chk_host_group: assert property (
        reg_rd && reg_addr[11:8] == 4'h1 && reg_addr[5:0] == 6'h20
        |=> reg_rdata[13:12] != 2'h0) else $error("host group out of range");
    chk_counter_bcd: assert property (
        reg_rd && reg_addr[11:6] == 6'h01 |=> is_bcd(reg_rdata)) else $error("counter not BCD");
endmodule // lsc_stats_monitor
bind lsc_stats lsc_stats_monitor i_lsc_stats_monitor (.clock(clock), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_deferred(tx_deferred), .link_sel(link_sel),
    .lk_i_sent(lk_i_sent), .lk_init(lk_init), .lk_cmd_rx_stb(lk_cmd_rx_stb),
    .lk_cmd_rx_code(lk_cmd_rx_code));
`default_nettype wire

/* File: lsc_stats_tb.sv */
// Self-checking testbench for the LAN link statistics counter block.
`timescale 1ns/1ps
`default_nettype none
module lsc_stats_tb;
    logic        clock, nrst, reg_wr, reg_rd, go, fcs, crx, ctx;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata;
    logic [7:0]  ad, code;
    logic [5:0]  lk;
    logic [1:0]  link_sel;
    logic [9:0]  ticks;
    wire logic [31:0] reg_rdata;
    wire logic   tx_start, bit_tick, collision, tx_end, done;
    int          n_errors, checked;
    lsc_stats i_lsc_stats (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tx_start(tx_start), .tx_end(tx_end), .bit_tick(bit_tick), .collision(collision),
        .tx_deferred(ad[0]), .tx_mac_error(ad[2]), .tx_carrier_lost(ad[3]),
        .tx_excess_coll(ad[4]), .rx_too_long(ad[5]), .rx_too_short(ad[6]),
        .rx_mac_error(ad[7]), .link_sel(link_sel), .lk_i_sent(lk[0]), .lk_i_rcvd(lk[1]),
        .lk_retx_needed(lk[2]), .lk_i_rx_err(lk[3]), .lk_fcs_bad(fcs),
        .lk_reply_expired(lk[4]), .lk_cmd_rx_stb(crx), .lk_cmd_rx_code(code),
        .lk_cmd_tx_stb(ctx), .lk_cmd_tx_code(code), .lk_init(lk[5]));
    lsc_medium i_lsc_medium (.clock(clock), .go(go), .ticks(ticks), .tx_start(tx_start),
        .bit_tick(bit_tick), .collision(collision), .tx_end(tx_end), .done(done));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic finish_test;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Every bus task ends 1 ns after an edge so that strobes never toggle twice at once.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clock); reg_wr <= 1'b0; #1;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clock); reg_rd <= 1'b0; #1;
        chk($sformatf("reg %h", a), e, reg_rdata);
    endtask
    task automatic pulse_ad(input int i);
        ad <= 8'h01 << i; @(posedge clock); ad <= 8'h00; #1;
    endtask
    task automatic pulse_lk(input int i);
        lk <= 6'h01 << i; @(posedge clock); lk <= 6'h00; #1;
    endtask
    function automatic logic [31:0] bcd(input int n);
        return {24'h0, 4'(n / 10), 4'(n % 10)};
    endfunction
    task automatic med(input logic [9:0] n);
        go <= 1'b1; ticks <= n; @(posedge clock); go <= 1'b0; #1;
        for (int i = 0; i < 2000 && !done; i++) begin
            @(posedge clock); #1;
        end
        if (!done) begin n_errors++; finish_test; end
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        rd(12'h11C, 32'h80);
        rd(12'h120, 32'h1004);
        rd(12'h118, 32'h0);
    endtask
    task automatic t_adapter;
        for (int i = 0; i < 8; i++) if (i != 1) repeat (i + 3) pulse_ad(i);
        for (int i = 0; i < 8; i++) if (i != 1) rd(12'h040 + 12'(4 * i), bcd(i + 3));
        wr(12'h000, 32'h1); rd(12'h040, 32'h0); rd(12'h05C, 32'h0);
        wr(12'h000, 32'h1); pulse_ad(0); rd(12'h040, 32'h1);
    endtask
    task automatic t_late;
        med(10'd512); rd(12'h044, 32'h0);
        med(10'd513); rd(12'h044, 32'h1);
    endtask
    task automatic t_link;
        for (int k = 0; k < 5; k++) repeat (k + 1) pulse_lk(k);
        fcs <= 1'b1; pulse_lk(3); fcs <= 1'b0;
        for (int k = 0; k < 5; k++) rd(12'h100 + 12'(4 * k), bcd(k + 1));
        pulse_lk(5); rd(12'h100, 32'h0); rd(12'h110, 32'h0);
        pulse_lk(0); wr(12'h124, 32'h1); rd(12'h100, 32'h0);
        pulse_lk(1); wr(12'h000, 32'h2); rd(12'h104, 32'h0);
    endtask
    task automatic t_codes;
        link_sel <= 2'h1; code <= 8'h1B; ctx <= 1'b1; @(posedge clock);
        ctx <= 1'b0; code <= 8'h83; crx <= 1'b1; @(posedge clock); crx <= 1'b0;
        rd(12'h158, 32'h1B83);
        wr(12'h158, 32'h10000); rd(12'h158, 32'h11B83);
        wr(12'h158, 32'h0); rd(12'h158, 32'h1B83);
    endtask
    task automatic t_state;
        wr(12'h11C, 32'h0203); rd(12'h11C, 32'h0280);
        wr(12'h11C, 32'h0201); rd(12'h11C, 32'h0201);
        wr(12'h120, 32'h0704); rd(12'h120, 32'h1004);
        wr(12'h120, 32'h3708); rd(12'h120, 32'h3708);
        wr(12'h004, 32'h104); wr(12'h008, 32'h4000); rd(12'h004, 32'h104);
        rd(12'h008, 32'h4000); rd(12'h3FC, 32'h0);
    endtask
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        {nrst, reg_wr, reg_rd, go, fcs, crx, ctx} = 7'h0;
        {reg_addr, reg_wdata, ad, code, lk, link_sel, ticks} = '0;
        n_errors = 0;
        checked = 0;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock); #1;
        t_reset; t_adapter; t_late; t_link; t_codes; t_state;
        finish_test;
    end
endmodule // lsc_stats_tb
`default_nettype wire
